// [shared/rpm_pkg.sv]
// Constants, register map and state codes of the regulator power manager.
// Assumes a single 25 MHz reference clock and word-aligned register access.
package rpm_pkg;

	// ============================================================
	// Register bus
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned DATA_W  = 32;

	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_EVENT   = 8'h08;
	localparam logic [7:0] OFF_WAKECNT = 8'h0C;

	// ============================================================
	// Field positions
	localparam int unsigned CTRL_REQ_BIT     = 0;
	localparam int unsigned ST_EN_BIT        = 0;
	localparam int unsigned ST_GOOD_BIT      = 1;
	localparam int unsigned ST_PUB_BIT       = 2;
	localparam int unsigned ST_TRST_BIT      = 3;
	localparam int unsigned ST_REQ_BIT       = 4;
	localparam int unsigned ST_PINHOLD_BIT   = 5;
	localparam int unsigned ST_TRSTHOLD_BIT  = 6;
	localparam int unsigned ST_STATE_LSB     = 8;
	localparam int unsigned EV_WAKE_BIT      = 0;
	localparam int unsigned EV_OFF_BIT       = 1;
	localparam int unsigned EV_N             = 2;

	// ============================================================
	// Reset values
	localparam logic [DATA_W-1:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [7:0]        RST_WAKECNT = 8'h00;
	localparam logic [EV_N-1:0]   RST_EVENT  = 2'h0;

	// ============================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned GOOD_DELAY_NS  = 640;
	localparam int unsigned GOOD_DELAY_CYC =
		(GOOD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 5;
	localparam logic [CNT_W-1:0] GOOD_CNT_LAST =
		CNT_W'(GOOD_DELAY_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

	// ============================================================
	// Core supply states, one-hot
	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_RAMP = 3'b010,
		ST_GOOD = 3'b100
	} rpm_state_t;

endpackage

// [shared/rpm_wake_if.sv]
// Carries the qualified wake edge from the edge stage to the manager.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps

interface rpm_wake_if;
	logic rise;   // One-cycle pulse on a low-to-high match
	logic level;  // Registered match level

	modport src (output rise, output level);
	modport dst (input rise, input level);
endinterface

// [logic/rpm_wake_edge.sv]
// Edge stage for the clock match wake input.
// Assumes the match input is synchronous to the reference clock.
`timescale 1ns/1ps

module rpm_wake_edge (
	input  wire logic i_ref_clk,   // Reference clock
	input  wire logic i_rstn,      // Async reset, active low
	input  wire logic i_match,     // Clock match wake level
	rpm_wake_if.src   wake         // Edge toward the manager
);

	logic prev_q;
	logic rise_q;
	wire  rise_d = i_match & ~prev_q;

	// ============================================================
	// Edge detection
	// Previous level resets high so a match held across reset is no wake
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			prev_q <= 1'b1;
			rise_q <= 1'b0;
		end else begin
			prev_q <= i_match;
			rise_q <= rise_d;  // [R4]
		end
	end

	assign wake.rise  = rise_q;
	assign wake.level = prev_q;

endmodule

// [logic/rpm_regulator_power_manager.sv]
// Regulator power manager: decides when the core regulator is enabled.
// Assumes synchronous pins, one 25 MHz clock and a plain register port.
//
// Operation
// R1 - Fabric keeps the regulator on by holding the power-up request high.
// R2 - Dropping the request turns the regulator off only with the bar pin high and test reset low.
// R3 - The initial-state tie picks the regulator state when supply comes up.
// R4 - A rising edge on the clock match wake input switches the regulator on.
// R5 - A low power-up-bar pin keeps the regulator enabled regardless of all else.
// R6 - A high test reset keeps the regulator enabled regardless of all else.
// R7 - Core good shows the fabric powered and working; its low is never seen by fabric.
// R8 - The core power-up output is always the inverse of the power-up-bar pin; here it is the registered inverse, one cycle late and 0 in reset.
// R9 - The regulator enable output is 1 to enable and 0 to disable the regulator.
// R10 - Test reset and regulator enable are internal wires, not fabric macro ports; here both are ports of the manager and are read in the status word.
// R11 - Enable is request or bar pin low or test reset high or a match edge, else off.
`timescale 1ns/1ps

module rpm_regulator_power_manager (
	input  wire logic        i_ref_clk,               // Reference clock
	input  wire logic        i_rstn,                  // Async reset, low
	input  wire logic [7:0]  i_addr,                  // Register address
	input  wire logic [31:0] i_wdata,                 // Write data
	input  wire logic        i_wr,                    // Write strobe
	input  wire logic        i_rd,                    // Read strobe
	output logic      [31:0] o_rdata,                 // Read data, next cycle
	input  wire logic        i_reg_initial_state_tie, // Initial state tie
	input  wire logic        i_clock_match_wake,      // Clock match wake
	input  wire logic        i_power_up_bar_pin,      // Power-up-bar pin
	input  wire logic        i_test_reset,            // Test reset pin
	output logic             o_regulator_enable_out,  // Regulator enable
	output logic             o_core_good,             // Core good
	output logic             o_core_powerup_out       // Inverse of bar pin
);

	// ============================================================
	// Address decode
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	wire wr_ctrl    = i_wr & addr_hit(i_addr, rpm_pkg::OFF_CTRL);
	wire wr_event   = i_wr & addr_hit(i_addr, rpm_pkg::OFF_EVENT);
	wire wr_wakecnt = i_wr & addr_hit(i_addr, rpm_pkg::OFF_WAKECNT);
	wire rd_ctrl    = addr_hit(i_addr, rpm_pkg::OFF_CTRL);
	wire rd_status  = addr_hit(i_addr, rpm_pkg::OFF_STATUS);
	wire rd_event   = addr_hit(i_addr, rpm_pkg::OFF_EVENT);
	wire rd_wakecnt = addr_hit(i_addr, rpm_pkg::OFF_WAKECNT);

	// ============================================================
	// Wake edge stage
	rpm_wake_if wake ();

	rpm_wake_edge u_wake_edge (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_match   (i_clock_match_wake),
		.wake      (wake.src)
	);

	// ============================================================
	// State
	logic                   init_done_q;
	logic                   req_q;
	logic                   req_d;
	logic                   en_q;
	logic                   good_q;
	logic                   core_powerup_out_q;
	logic [31:0]            rdata_q;
	logic [31:0]            rdata_d;
	logic [7:0]             wakecnt_q;
	logic [7:0]             wakecnt_d;
	logic [rpm_pkg::EV_N-1:0] event_q;
	logic [rpm_pkg::EV_N-1:0] event_set;
	logic [rpm_pkg::CNT_W-1:0] cnt_q;
	logic [rpm_pkg::CNT_W-1:0] cnt_d;
	rpm_pkg::rpm_state_t    state_q;
	rpm_pkg::rpm_state_t    state_d;

	// ============================================================
	// Hold sources
	wire pin_hold  = ~i_power_up_bar_pin;                     // [R5]
	wire trst_hold = i_test_reset;                            // [R6]
	wire en_d      = req_q | pin_hold | trst_hold;            // [R11] [R1]
	wire en_fall   = en_q & ~en_d;

	// ============================================================
	// Power-up request
	// The wake edge is folded into the request so the regulator stays on
	// after the one-cycle pulse; a clear in the same cycle loses.
	always_comb begin
		req_d = req_q;
		if (!init_done_q) begin
			req_d = i_reg_initial_state_tie;                  // [R3]
		end else if (wake.rise) begin
			req_d = 1'b1;                                     // [R4] [R11]
		end else if (wr_ctrl) begin
			req_d = i_wdata[rpm_pkg::CTRL_REQ_BIT];           // [R1] [R2]
		end
	end

	// Tie is caught on the first edge after reset release
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			init_done_q <= 1'b0;
			req_q       <= 1'b0;
		end else begin
			init_done_q <= 1'b1;
			req_q       <= req_d;
		end
	end

	// ============================================================
	// Regulator enable and pin mirror
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			en_q     <= 1'b0;
			core_powerup_out_q <= 1'b0;
		end else begin
			en_q     <= en_d;                                 // [R9] [R2]
			core_powerup_out_q <= ~i_power_up_bar_pin;                  // [R8]
		end
	end

	// ============================================================
	// Core supply sequencing
	// Good is withheld until the ramp delay has passed after enable.
	wire cnt_done = (cnt_q == rpm_pkg::GOOD_CNT_LAST);

	always_comb begin
		state_d = state_q;
		cnt_d   = rpm_pkg::CNT_ZERO;
		unique case (state_q)
			rpm_pkg::ST_OFF: begin
				if (en_q) begin
					state_d = rpm_pkg::ST_RAMP;
				end
			end
			rpm_pkg::ST_RAMP: begin
				if (!en_q) begin
					state_d = rpm_pkg::ST_OFF;
				end else if (cnt_done) begin
					state_d = rpm_pkg::ST_GOOD;
				end else begin
					cnt_d = cnt_q + 5'h01;
				end
			end
			rpm_pkg::ST_GOOD: begin
				if (!en_q) begin
					state_d = rpm_pkg::ST_OFF;
				end
			end
			default: begin
				state_d = rpm_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= rpm_pkg::ST_OFF;
			cnt_q   <= rpm_pkg::CNT_ZERO;
			good_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			good_q  <= (state_d == rpm_pkg::ST_GOOD);         // [R7]
		end
	end

	// ============================================================
	// Sticky events, write one to clear, set wins
	assign event_set[rpm_pkg::EV_WAKE_BIT] = wake.rise;
	assign event_set[rpm_pkg::EV_OFF_BIT]  = en_fall;

	genvar gi;
	generate
		for (gi = 0; gi < rpm_pkg::EV_N; gi++) begin : g_event
			wire clr = wr_event & i_wdata[gi];
			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					event_q[gi] <= 1'b0;
				end else if (event_set[gi]) begin
					event_q[gi] <= 1'b1;
				end else if (clr) begin
					event_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ============================================================
	// Wake counter, wraps; any write zeroes it unless a wake lands
	always_comb begin
		wakecnt_d = wakecnt_q;
		if (wake.rise) begin
			wakecnt_d = wakecnt_q + 8'h01;
		end else if (wr_wakecnt) begin
			wakecnt_d = rpm_pkg::RST_WAKECNT;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wakecnt_q <= rpm_pkg::RST_WAKECNT;
		end else begin
			wakecnt_q <= wakecnt_d;
		end
	end

	// ============================================================
	// Read path
	// Data stands only in the cycle after the strobe; unmapped reads zero.
	wire [31:0] status_word = {
		21'h000000,
		state_q,
		1'b0,
		trst_hold,
		pin_hold,
		req_q,
		i_test_reset,
		i_power_up_bar_pin,
		good_q,
		en_q
	};

	always_comb begin
		rdata_d = rpm_pkg::RST_ZERO;
		if (i_rd) begin
			if (rd_ctrl) begin
				rdata_d = {31'h00000000, req_q};
			end else if (rd_status) begin
				rdata_d = status_word;
			end else if (rd_event) begin
				rdata_d = {30'h00000000, event_q};
			end else if (rd_wakecnt) begin
				rdata_d = {24'h000000, wakecnt_q};
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_q <= rpm_pkg::RST_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ============================================================
	// Outputs
	// Enable and test reset stay inside the device; fabric reads both in the status word.
	assign o_rdata                = rdata_q;
	assign o_regulator_enable_out = en_q;                     // [R10]
	assign o_core_good            = good_q;
	assign o_core_powerup_out     = core_powerup_out_q;

endmodule

// [bench/rpm_chk_sva.sv]
// Port checker for the regulator power manager.
// Bound from the bench top; one clock, async active-low reset.
`timescale 1ns/1ps
module rpm_chk (
	input wire logic        i_ref_clk,              // Clock
	input wire logic        i_rstn,                 // Reset, low
	input wire logic        i_rd,                   // Read strobe
	input wire logic [31:0] o_rdata,                // Read data
	input wire logic        i_clock_match_wake,     // Match
	input wire logic        i_power_up_bar_pin,     // Bar pin
	input wire logic        i_test_reset,           // Test reset
	input wire logic        o_regulator_enable_out, // Enable
	input wire logic        o_core_good,            // Core good
	input wire logic        o_core_powerup_out      // Inverse pin
);
	// ============================================================
	// Enable-high run length, saturating
	logic [5:0] en_cnt_q;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			en_cnt_q <= 6'h00;
		else if (!o_regulator_enable_out)
			en_cnt_q <= 6'h00;
		else if (en_cnt_q != 6'h3F)
			en_cnt_q <= en_cnt_q + 6'h01;
	end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	// ============================================================
	// Properties
	chk_pin_holds_en: assert property (
		$past(i_rstn) && !i_power_up_bar_pin |=> o_regulator_enable_out)
		else $error("bar pin low did not enable");
	chk_trst_holds_en: assert property (
		$past(i_rstn) && i_test_reset |=> o_regulator_enable_out)
		else $error("test reset high did not enable");
	chk_wake_edge_on: assert property (
		$past(i_rstn) && $rose(i_clock_match_wake)
		|-> ##3 o_regulator_enable_out)
		else $error("match edge did not enable");
	chk_off_needs_pins: assert property (
		$fell(o_regulator_enable_out)
		|-> $past(i_power_up_bar_pin) && !$past(i_test_reset))
		else $error("enable fell while a pin forced it");
	chk_powerup_inverse: assert property (
		$past(i_rstn) |-> o_core_powerup_out == !$past(i_power_up_bar_pin))
		else $error("core powerup not inverse of pin");
	chk_good_not_early: assert property (
		o_core_good |-> en_cnt_q >= 6'h11)
		else $error("core good before ramp end");
	chk_good_not_late: assert property (
		en_cnt_q == 6'h13 |-> o_core_good)
		else $error("core good missing after ramp");
	chk_good_drops: assert property (
		!o_regulator_enable_out |=> !o_core_good)
		else $error("core good held without enable");
	chk_rdata_idle: assert property (
		!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside read slot");

	cov_wake: cover property ($rose(i_clock_match_wake));
	cov_good: cover property ($rose(o_core_good));
	cov_off: cover property ($fell(o_regulator_enable_out));
endmodule

// [bench/rpm_board_model.sv]
// Board pins and clock-match source around the power manager.
// Commanded by the bench; levels settle at once.
`timescale 1ns/1ps
module rpm_board_model (
	input  wire logic i_pin_low,   // Ground the bar pin
	input  wire logic i_trst_high, // Raise test reset
	input  wire logic i_wake,      // Raise clock match
	output logic      o_pin,       // Bar pin level
	output logic      o_trst,      // Test reset level
	output logic      o_match      // Clock match level
);
	// ============================================================
	// Weak pull-up wins while nobody grounds the pin
	assign o_pin   = i_pin_low ? 1'b0 : 1'b1;
	assign o_trst  = i_trst_high;
	assign o_match = i_wake;
endmodule

// [bench/tb.sv]
// Self-checking bench for the regulator power manager.
// Board model drives the pins; registers over the plain port.
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        tie = 1'b0;
	logic        pin_low = 1'b0;
	logic        trst_hi = 1'b0;
	logic        wake = 1'b0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic        en;
	logic        good;
	logic        pwr;
	logic        pin;
	logic        trst;
	logic        match;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;

	always #20 clk = ~clk;

	rpm_regulator_power_manager i_rpm_regulator_power_manager (
		.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_reg_initial_state_tie(tie), .i_clock_match_wake(match),
		.i_power_up_bar_pin(pin), .i_test_reset(trst),
		.o_regulator_enable_out(en), .o_core_good(good),
		.o_core_powerup_out(pwr));
	rpm_board_model i_rpm_board_model (.i_pin_low(pin_low),
		.i_trst_high(trst_hi), .i_wake(wake), .o_pin(pin),
		.o_trst(trst), .o_match(match));

	// ============================================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic do_reset(input logic t);
		@(posedge clk);
		rstn <= 1'b0;
		tie <= t;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_init();
		do_reset(1'b0);
		tick(2);
		check(32'(en), 32'h0);
		bus_rd(8'h40, d);
		check(d, 32'h0);
		do_reset(1'b1);
		tick(1);
		check(32'(en), 32'h0);
		tick(1);
		check(32'(en), 32'h1);
		bus_wr(rpm_pkg::OFF_CTRL, 32'h0);
		tick(1);
		check(32'(en), 32'h0);
	endtask
	task automatic t_req();
		bus_wr(rpm_pkg::OFF_CTRL, 32'h1);
		tick(0);
		check(32'(en), 32'h0);
		tick(1);
		check(32'(en), 32'h1);
		tick(16);
		check(32'(good), 32'h0);
		tick(1);
		check(32'(good), 32'h1);
		bus_rd(rpm_pkg::OFF_STATUS, d);
		check({21'h0, d[10:0]}, 32'h0000_0417);
		bus_wr(rpm_pkg::OFF_CTRL, 32'h0);
		tick(1);
		check(32'(en), 32'h0);
		tick(1);
		check(32'(good), 32'h0);
	endtask
	task automatic t_force();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			pin_low <= (k == 0);
			trst_hi <= (k == 1);
			tick(1);
			check(32'(en), 32'h1);
			check(32'(pwr), 32'(k == 0));
			bus_wr(rpm_pkg::OFF_CTRL, 32'h0);
			tick(2);
			check(32'(en), 32'h1);
			@(posedge clk);
			pin_low <= 1'b0;
			trst_hi <= 1'b0;
			tick(1);
			check(32'(en), 32'h0);
			check(32'(pwr), 32'h0);
		end
	endtask
	task automatic t_wake();
		@(posedge clk);
		wake <= 1'b1;
		tick(2);
		check(32'(en), 32'h0);
		tick(1);
		check(32'(en), 32'h1);
		bus_rd(rpm_pkg::OFF_WAKECNT, d);
		check({24'h0, d[7:0]}, 32'h1);
		bus_wr(rpm_pkg::OFF_CTRL, 32'h0);
		tick(1);
		check(32'(en), 32'h0);
		// Both sticky events stand: wake seen and enable fell
		bus_rd(rpm_pkg::OFF_EVENT, d);
		check(d, 32'h0000_0003);
		bus_wr(rpm_pkg::OFF_EVENT, 32'h0000_0003);
		bus_rd(rpm_pkg::OFF_EVENT, d);
		check(d, 32'h0000_0000);
		bus_wr(rpm_pkg::OFF_WAKECNT, 32'h0000_0000);
		bus_rd(rpm_pkg::OFF_WAKECNT, d);
		check(d, 32'h0000_0000);
		bus_rd(rpm_pkg::OFF_CTRL, d);
		check(d, 32'h0000_0000);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			test_done();
		end
	end

	initial begin
		t_init();
		t_req();
		t_force();
		t_wake();
		test_done();
	end
endmodule

bind rpm_regulator_power_manager rpm_chk i_rpm_chk (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_clock_match_wake(i_clock_match_wake),
	.i_power_up_bar_pin(i_power_up_bar_pin), .i_test_reset(i_test_reset),
	.o_regulator_enable_out(o_regulator_enable_out),
	.o_core_good(o_core_good), .o_core_powerup_out(o_core_powerup_out));
